/* bcdad_core.sv */
// ----------------------------------------
// Overview of operation
// ----------------------------------------
// Overview of operation
// - Decimal adjust turns accumulator after BCD binary addition into packed BCD.
// - Low nibble above 9 or half-byte carry set: add 6 to it.
// - High nibble above 9 or carry set: add 6 and set carry.
// - Decrement file register; destination bit picks accumulator (0) or register (1).
// - Bank bit zero selects access bank (idx_base_reg offset if ext bit set and address <= 0x5f); one uses bank select pointer.
`include "bcdad_defs.svh"
`default_nettype none
module bcdad_core
    import bcdad_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic             busy_o
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0]   acc_reg;
    logic [3:0]   bank_select_pointer_reg;
    logic [11:0]  idx_base_reg;
    logic [7:0]   faddr_reg;
    logic         dest_reg;
    logic         bank_reg;
    logic         ext_reg;
    bcdad_op_t    op_reg;
    bcdad_phase_t phase_reg;
    logic         active_reg;
    logic         c_reg, dc_reg, z_reg, n_reg;
    logic [7:0]   operand_reg;
    logic [7:0]   result_reg;
    logic         c_res_reg, dc_res_reg;
    logic [3:0]   slot_reg;
    logic         ack_reg;
    logic [7:0]   file_mem [`BCDAD_MEM_DEPTH];
    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    // Ack blocks a second take while the strobe is still held
    wire req     = cyc_i & stb_i & ~ack_reg;
    wire wr      = req & we_i;
    wire hit_ctl = adr_i == `BCDAD_OFF_CTRL;
    wire hit_acc = adr_i == `BCDAD_OFF_ACC;
    wire hit_st  = adr_i == `BCDAD_OFF_STATUS;
    wire hit_bk  = adr_i == `BCDAD_OFF_BANK;
    // A start while busy is dropped whole, its other fields too
    wire go      = wr & hit_ctl & sel_i[1] & dat_i[`BCDAD_CTRL_GO_BIT] & ~active_reg;
    wire [1:0] op_field = dat_i[`BCDAD_CTRL_OP_LSB +: 2];
    // ----------------------------------------
    // Address formation
    // ----------------------------------------
    wire use_idx = ~bank_reg & ext_reg & (faddr_reg <= `BCDAD_IDX_LIMIT);
    wire [11:0] idx_addr = idx_base_reg + {4'h0, faddr_reg};
    wire [3:0] acc_bank = faddr_reg < `BCDAD_ACCESS_HI ? 4'h0 : `BCDAD_ACCESS_SFR;
    wire [11:0] full_addr = use_idx ? idx_addr :
                            bank_reg ? {bank_select_pointer_reg, faddr_reg} :
                            {acc_bank, faddr_reg};
    // Only a small window of the data space is stored; upper address bits fold
    wire [3:0] slot = full_addr[3:0];
    // ----------------------------------------
    // Datapath
    // ----------------------------------------
    logic [7:0] adj_res;
    logic       adj_c;
    bcdad_adjust u_adjust (
        .acc_i                  (operand_reg),
        .carry_i                (c_reg),
        .half_byte_carry_flag_i (dc_reg),
        .result_o               (adj_res),
        .carry_o                (adj_c)
    );
    wire [7:0] dec_res = operand_reg - 8'h01;
    wire       dec_c   = operand_reg != 8'h00;
    wire       dec_dc  = operand_reg[3:0] != 4'h0;
    wire       is_adj  = op_reg == BCDAD_OP_ADJ;
    wire       wr_file = ~is_adj & dest_reg;
    // ----------------------------------------
    // Phase sequencer
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_reg  <= BCDAD_Q1;
            active_reg <= 1'b0;
        end else if (go && op_field != BCDAD_OP_NONE) begin
            phase_reg  <= BCDAD_Q1;
            active_reg <= 1'b1;
        end else if (active_reg) begin
            case (phase_reg)
                BCDAD_Q1: phase_reg <= BCDAD_Q2;
                BCDAD_Q2: phase_reg <= BCDAD_Q3;
                BCDAD_Q3: phase_reg <= BCDAD_Q4;
                BCDAD_Q4: begin
                    phase_reg  <= BCDAD_Q1;
                    active_reg <= 1'b0;
                end
                default: phase_reg <= BCDAD_Q1;
            endcase
        end
    end
    // ----------------------------------------
    // Decode latch, operand read, process
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            op_reg      <= BCDAD_OP_NONE;
            faddr_reg   <= 8'h00;
            dest_reg    <= 1'b1;
            bank_reg    <= 1'b1;
            ext_reg     <= 1'b0;
            operand_reg <= 8'h00;
            result_reg  <= 8'h00;
            c_res_reg   <= 1'b0;
            dc_res_reg  <= 1'b0;
            slot_reg    <= 4'h0;
        end else begin
            if (go) begin
                op_reg    <= bcdad_op_t'(op_field);
                faddr_reg <= dat_i[`BCDAD_CTRL_ADDR_LSB +: 8];
                dest_reg  <= dat_i[`BCDAD_CTRL_DEST_BIT];
                bank_reg  <= dat_i[`BCDAD_CTRL_BANK_BIT];
                ext_reg   <= dat_i[`BCDAD_CTRL_EXT_BIT];
            end
            if (active_reg && phase_reg == BCDAD_Q2) begin
                operand_reg <= is_adj ? acc_reg : file_mem[slot];
                slot_reg    <= slot;
            end
            if (active_reg && phase_reg == BCDAD_Q3) begin
                result_reg <= is_adj ? adj_res : dec_res;
                c_res_reg  <= is_adj ? adj_c : dec_c;
                dc_res_reg <= is_adj ? dc_reg : dec_dc;
            end
        end
    end
    // ----------------------------------------
    // Write-back in the final phase
    // ----------------------------------------
    wire wb       = active_reg & (phase_reg == BCDAD_Q4);
    wire wb_acc   = wb & ~wr_file;
    wire wb_flags = wb;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_reg <= `BCDAD_ACC_RST;
            c_reg   <= 1'b0;
            dc_reg  <= 1'b0;
            z_reg   <= 1'b0;
            n_reg   <= 1'b0;
        end else if (wb_acc) begin
            acc_reg <= result_reg;
        end else if (wr && hit_acc && sel_i[0]) begin
            acc_reg <= dat_i[7:0];
        end
        if (!rst_i) begin
            // Hardware update in phase 4 wins over a software status write
            if (wb_flags) begin
                c_reg  <= c_res_reg;
                dc_reg <= dc_res_reg;
                z_reg  <= is_adj ? z_reg : result_reg == 8'h00;
                n_reg  <= is_adj ? n_reg : result_reg[7];
            end else if (wr && hit_st && sel_i[0]) begin
                c_reg  <= dat_i[`BCDAD_ST_C_BIT];
                dc_reg <= dat_i[`BCDAD_ST_DC_BIT];
                z_reg  <= dat_i[`BCDAD_ST_Z_BIT];
                n_reg  <= dat_i[`BCDAD_ST_N_BIT];
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bank_select_pointer_reg <= `BCDAD_BANK_RST;
            idx_base_reg            <= `BCDAD_IDX_BASE_RST;
        end else if (wr && hit_bk) begin
            if (sel_i[0]) bank_select_pointer_reg <= dat_i[3:0];
            if (sel_i[2]) idx_base_reg[7:0] <= dat_i[23:16];
            if (sel_i[3]) idx_base_reg[11:8] <= dat_i[27:24];
        end
    end
    // Cleared at reset: software has no other way to load a byte, and a
    // decrement of an unknown byte would give nothing to check against
    for (genvar gi = 0; gi < `BCDAD_MEM_DEPTH; gi++) begin : g_file
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                file_mem[gi] <= `BCDAD_FILE_RST;
            end else if (wb && wr_file && slot_reg == 4'(gi)) begin
                file_mem[gi] <= result_reg;
            end
        end
    end
    // ----------------------------------------
    // Bus answer
    // ----------------------------------------
    wire [31:0] ctl_rd = {16'h0, active_reg, 1'b0, op_reg, 1'b0, ext_reg, bank_reg,
                          dest_reg, faddr_reg};
    wire [31:0] st_rd  = {27'h0, active_reg, n_reg, z_reg, dc_reg, c_reg};
    wire [31:0] bk_rd  = {4'h0, idx_base_reg, 12'h0, bank_select_pointer_reg};
    wire [31:0] rd_mux = hit_ctl ? ctl_rd :
                         hit_acc ? {24'h0, acc_reg} :
                         hit_st  ? st_rd :
                         hit_bk  ? bk_rd : 32'h0;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_o   <= 32'h0;
        end else begin
            ack_reg <= req;
            dat_o   <= req ? rd_mux : dat_o;
        end
    end
    assign ack_o  = ack_reg;
    assign busy_o = active_reg;
endmodule
`default_nettype wire

/* bcdad_defs.svh */
`ifndef BCDAD_DEFS_SVH
`define BCDAD_DEFS_SVH
// ----------------------------------------
// Register map (word byte addresses)
// ----------------------------------------
`define BCDAD_OFF_CTRL      4'h0
`define BCDAD_OFF_ACC       4'h4
`define BCDAD_OFF_STATUS    4'h8
`define BCDAD_OFF_BANK      4'hc
// ----------------------------------------
// Control fields
// ----------------------------------------
`define BCDAD_CTRL_ADDR_LSB 0
`define BCDAD_CTRL_DEST_BIT 8
`define BCDAD_CTRL_BANK_BIT 9
`define BCDAD_CTRL_EXT_BIT  10
`define BCDAD_CTRL_OP_LSB   12
`define BCDAD_CTRL_GO_BIT   15
// ----------------------------------------
// Status fields
// ----------------------------------------
`define BCDAD_ST_C_BIT      0
`define BCDAD_ST_DC_BIT     1
`define BCDAD_ST_Z_BIT      2
`define BCDAD_ST_N_BIT      3
`define BCDAD_ST_BUSY_BIT   4
// ----------------------------------------
// Numbers
// ----------------------------------------
`define BCDAD_NIB_MAX       4'h9
`define BCDAD_NIB_ADJ       4'h6
`define BCDAD_IDX_LIMIT     8'h5f
`define BCDAD_ACC_RST       8'h00
`define BCDAD_BANK_RST      4'h0
`define BCDAD_IDX_BASE_RST  12'h000
`define BCDAD_FILE_RST      8'h00
`define BCDAD_ACCESS_HI     8'h80
`define BCDAD_ACCESS_SFR    4'hf
`define BCDAD_MEM_DEPTH     16
`endif

/* bcdad_pkg.sv */
`default_nettype none
package bcdad_pkg;
    typedef enum logic [1:0] {
        BCDAD_OP_NONE = 2'h0,
        BCDAD_OP_ADJ  = 2'h1,
        BCDAD_OP_DEC  = 2'h2
    } bcdad_op_t;
    typedef enum logic [3:0] {
        BCDAD_Q1 = 4'b0001,
        BCDAD_Q2 = 4'b0010,
        BCDAD_Q3 = 4'b0100,
        BCDAD_Q4 = 4'b1000
    } bcdad_phase_t;
endpackage
`default_nettype wire

/* bcdad_adjust.sv */
`include "bcdad_defs.svh"
`default_nettype none
module bcdad_adjust
    import bcdad_pkg::*;
(
    input  wire logic [7:0] acc_i,
    input  wire logic       carry_i,
    input  wire logic       half_byte_carry_flag_i,
    output logic      [7:0] result_o,
    output logic            carry_o
);
    wire       lo_fix = (acc_i[3:0] > `BCDAD_NIB_MAX) | half_byte_carry_flag_i;
    wire [4:0] lo_sum = {1'b0, acc_i[3:0]} + {1'b0, `BCDAD_NIB_ADJ};
    // Low-nibble overflow ripples into the high digit before its test
    wire [3:0] hi_in  = acc_i[7:4] + {3'h0, lo_fix & lo_sum[4]};
    wire       hi_ovf = lo_fix & lo_sum[4] & (acc_i[7:4] == 4'hf);
    wire       hi_fix = (hi_in > `BCDAD_NIB_MAX) | carry_i | hi_ovf;
    wire [3:0] lo_out = lo_fix ? lo_sum[3:0] : acc_i[3:0];
    wire [3:0] hi_out = hi_fix ? hi_in + `BCDAD_NIB_ADJ : hi_in;
    assign result_o = {hi_out, lo_out};
    assign carry_o  = hi_fix | carry_i;
endmodule
`default_nettype wire

/* bcdad_core_properties.sv */
`default_nettype none
module bcdad_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [3:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        busy_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic take  = cyc_i && stb_i && !ack_o;
    wire logic ctrl  = take && we_i && adr_i == 4'h0 && sel_i[1];
    // Only a live start with a real operation code opens the four phases
    wire logic go_wr = ctrl && dat_i[15] && dat_i[13:12] != 2'h0 && !busy_o;
    ack_answer_a: assert property (take |=> ack_o) else $error("no ack after request");
    ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
    go_phases_a: assert property (go_wr |=> busy_o[*4] ##1 !busy_o) else $error("bad busy");
    busy_len_a: assert property ($rose(busy_o) |-> busy_o[*4] ##1 !busy_o) else $error("busy length");
    reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !ack_o && !busy_o && dat_o == 32'h0)
        else $error("outputs active in reset");
    hole_read_a: assert property (take && !we_i && adr_i[1:0] != 2'h0 |=> dat_o == 32'h0)
        else $error("unmapped read not zero");
    busy_flag_a: assert property (take && !we_i && adr_i == 4'h8 |=> dat_o[4] == $past(busy_o))
        else $error("status busy bit wrong");
    c_op: cover property (go_wr && dat_i[13:12] == 2'h1);
    c_dec: cover property (go_wr && dat_i[13:12] == 2'h2);
    c_refuse: cover property (ctrl && dat_i[15] && busy_o);
endmodule
bind bcdad_core bcdad_checker u_checker (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .busy_o(busy_o));
`default_nettype wire

/* tb_bcd_adjust_and_decrement.sv */
`include "bcdad_defs.svh"
`default_nettype none
module tb_bcd_adjust_and_decrement;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [3:0]  adr_i = 4'h0;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    wire logic [31:0] dat_o;
    wire logic        ack_o;
    wire logic        busy_o;
    logic [31:0] rd;
    logic [8:0]  e;
    logic [9:0]  cases [8] = '{10'h0a5, 10'h0ce, 10'h109, 10'h299, 10'h03a, 10'h015, 10'h187,
                               10'h0fa};
    logic [31:0] decs [5] = '{32'ha310, 32'ha454, 32'ha460, 32'ha1f0, 32'ha000};
    logic [7:0]  dacc [5] = '{8'h00, 8'hfe, 8'hfe, 8'hfe, 8'hfd};
    int          n_fail = 0;
    int          num_checks = 0;
    always #12.5 clk_i = ~clk_i;
    bcdad_core dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .busy_o(busy_o));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ----------------------------------------
    // Classic single cycle, released only after ack, then one idle cycle
    // ----------------------------------------
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hf;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 20);
        if (k == 20) begin
            n_fail++;
            $display("wrong value at %0t: ack 0x0 expected 0x1", $time);
            finish_test();
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got 0x%h expected 0x%h", $time, got, exp);
        end
    endtask
    // Carry flag comes back as bit 8
    function automatic logic [8:0] bcd_fix(input logic [7:0] a, input logic c, input logic h);
        logic [8:0] r;
        r = {1'b0, a};
        if (a[3:0] > 4'h9 || h) r = r + 9'h006;
        if (r[8] || r[7:4] > 4'h9 || c) r = {1'b1, r[7:0] + 8'h60};
        return r;
    endfunction
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, `BCDAD_OFF_ACC, 32'h0);
        check({24'h0, rd[7:0]}, 32'h0);
        wb(1'b0, `BCDAD_OFF_BANK, 32'h0);
        check(rd & 32'h0fff000f, 32'h0);
        wb(1'b1, `BCDAD_OFF_BANK, 32'h0abc0005);
        wb(1'b0, `BCDAD_OFF_BANK, 32'h0);
        check(rd & 32'h0fff000f, 32'h0abc0005);
        wb(1'b1, `BCDAD_OFF_STATUS, 32'h1f);
        wb(1'b0, `BCDAD_OFF_STATUS, 32'h0);
        check(rd & 32'h1f, 32'h0f);
        for (int i = 0; i < 8; i++) begin
            e = bcd_fix(cases[i][7:0], cases[i][9], cases[i][8]);
            wb(1'b1, `BCDAD_OFF_ACC, {24'h0, cases[i][7:0]});
            wb(1'b1, `BCDAD_OFF_STATUS, {30'h0, cases[i][8], cases[i][9]});
            wb(1'b1, `BCDAD_OFF_CTRL, 32'h9000);
            repeat (4) @(posedge clk_i);
            wb(1'b0, `BCDAD_OFF_ACC, 32'h0);
            check({24'h0, rd[7:0]}, {24'h0, e[7:0]});
            wb(1'b0, `BCDAD_OFF_STATUS, 32'h0);
            check({30'h0, rd[1:0]}, {30'h0, cases[i][8], e[8]});
        end
        wb(1'b1, `BCDAD_OFF_CTRL, 32'h9000);
        check({31'h0, busy_o}, 32'h1);
        wb(1'b0, `BCDAD_OFF_STATUS, 32'h0);
        check({31'h0, rd[4]}, 32'h1);
        // Second start lands while the first still runs and must be dropped
        wb(1'b1, `BCDAD_OFF_CTRL, 32'h9000);
        wb(1'b1, `BCDAD_OFF_CTRL, 32'ha3ff);
        wb(1'b0, `BCDAD_OFF_CTRL, 32'h0);
        check(rd & 32'hb000, 32'h1000);
        wb(1'b1, `BCDAD_OFF_ACC, 32'h0);
        for (int i = 0; i < 5; i++) begin
            wb(1'b1, `BCDAD_OFF_CTRL, decs[i]);
            repeat (4) @(posedge clk_i);
            wb(1'b0, `BCDAD_OFF_CTRL, 32'h0);
            check(rd & 32'hb7ff, decs[i] & 32'h37ff);
            wb(1'b0, `BCDAD_OFF_ACC, 32'h0);
            check({24'h0, rd[7:0]}, {24'h0, dacc[i]});
        end
        wb(1'b0, `BCDAD_OFF_STATUS, 32'h0);
        check(rd & 32'h1f, 32'h0b);
        wb(1'b1, `BCDAD_OFF_ACC, 32'h42);
        wb(1'b1, 4'h1, 32'hff);
        wb(1'b0, 4'h1, 32'h0);
        check(rd, 32'h0);
        wb(1'b0, `BCDAD_OFF_ACC, 32'h0);
        check({24'h0, rd[7:0]}, 32'h42);
        finish_test();
    end
endmodule
`default_nettype wire
